// File: rtl/arc_buf2.v
// Two-entry buffer between the averaging filter and the result store
`timescale 1ns/10ps
module arc_buf2 #(
  parameter WIDTH = 19
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_valid,
  output wire o_ready,
  input wire [WIDTH-1:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem0;
  reg [WIDTH-1:0] mem1;
  reg rd_ptr;
  reg wr_ptr;
  reg [1:0] count;
  wire do_wr;
  wire do_rd;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data = rd_ptr ? mem1 : mem0;
  assign do_wr = i_valid && o_ready;
  assign do_rd = o_valid && i_ready;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem0 <= {WIDTH{1'b0}};
      mem1 <= {WIDTH{1'b0}};
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_wr) begin
        if (wr_ptr) begin
          mem1 <= i_data;
        end else begin
          mem0 <= i_data;
        end
        wr_ptr <= ~wr_ptr;
      end
      if (do_rd) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule

// File: rtl/arc_defines.vh
// Constants for the converter readout and oversampling control block
`ifndef ARC_DEFINES_VH
`define ARC_DEFINES_VH
// ----------------------------------------------------------------------------
// Channel and word layout
// ----------------------------------------------------------------------------
`define ARC_NUM_CH 8
`define ARC_WORD_BITS 16
`define ARC_SER_BITS 5'h10
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ARC_CLK_MHZ 50
`define ARC_BASE_CONV_NS 4000
`define ARC_BASE_CONV_CYC ((`ARC_BASE_CONV_NS * `ARC_CLK_MHZ + 999) / 1000)
`define ARC_UPDATE_LEAD_CYC 16'h0004
// ----------------------------------------------------------------------------
// Interface kinds
// ----------------------------------------------------------------------------
`define ARC_IF_WORD 2'h0
`define ARC_IF_BYTE 2'h1
`define ARC_IF_SER 2'h2
`endif

// File: rtl/arc_readout_ctrl.v
// Readout control with read during conversion and oversampling
// Overview of operation
// - Reads are served while busy is high and a conversion runs.
// - Reads during conversion return the previous sample set.
// - Word, byte and serial readout all work at every ratio.
// - Output store updates just before busy falls; host keeps release delay.
// - Ratio pins are caught at busy fall, used for next conversion.
// - Busy time grows with the selected oversampling ratio.
// - Samples pass through an averaging filter before the output store.
// - Serial: sixteen clocks per channel, MSB first, ascending channels.
`timescale 1ns/10ps
`include "arc_defines.vh"
module arc_readout_ctrl #(
  parameter NUM_CH = `ARC_NUM_CH,
  parameter BASE_CONV_CYC = `ARC_BASE_CONV_CYC
) (
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_CONVERSION_START_GROUP_A,
  input wire I_CONVERSION_START_GROUP_B,
  input wire [2:0] I_OVERSAMPLE_RATIO_SELECT_PINS,
  input wire I_INTERFACE_KIND_SELECT,
  input wire I_BYTE_MODE_SELECT,
  input wire I_HIGH_BYTE_FIRST,
  input wire I_CS_N,
  input wire I_RD_N,
  input wire I_SCLK,
  input wire I_SAMPLE_VALID,
  input wire [15:0] I_SAMPLE_DATA,
  output reg O_SAMPLE_REQ,
  output reg O_BUSY,
  output reg [2:0] O_OVERSAMPLING_RATIO,
  output reg [15:0] O_DB,
  output reg O_DB_OE,
  output reg O_DOUT_A,
  output reg O_DOUT_B,
  output reg O_DOUT_OE,
  output reg O_FIRST_DATA,
  output reg O_FIRST_DATA_OE
);
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_FLUSH = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [1:0] state;
  reg [15:0] conv_cnt;
  reg [15:0] conv_len;
  reg [2:0] ch_idx;
  reg [6:0] avg_cnt;
  reg signed [22:0] acc;
  reg [15:0] store [0:NUM_CH-1];
  reg [15:0] pend [0:NUM_CH-1];
  reg set_done;
  reg conv_a_q;
  reg cs_q;
  reg rd_q;
  reg sclk_q;
  reg [3:0] rd_idx;
  reg [4:0] bit_cnt;
  reg [2:0] ser_ch;
  integer k;

  wire start_rise = I_CONVERSION_START_GROUP_A && I_CONVERSION_START_GROUP_B && !conv_a_q;
  wire [6:0] ratio_n = 7'h01 << O_OVERSAMPLING_RATIO;
  wire [22:0] sum_next = acc + {{7{I_SAMPLE_DATA[15]}}, I_SAMPLE_DATA};
  wire [1:0] if_kind = !I_INTERFACE_KIND_SELECT ? `ARC_IF_WORD :
                       (I_BYTE_MODE_SELECT ? `ARC_IF_BYTE : `ARC_IF_SER);
  wire cs_fall = cs_q && !I_CS_N;
  wire rd_fall = rd_q && !I_RD_N && !I_CS_N;
  wire sclk_rise = !sclk_q && I_SCLK && !I_CS_N;
  wire sclk_fall = sclk_q && !I_SCLK && !I_CS_N;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [18:0] buf_out;
  wire sample_take = I_SAMPLE_VALID && buf_in_ready && !set_done;
  wire last_ch = (ch_idx == NUM_CH[2:0] - 3'h1);
  wire buf_in_valid = (state == ST_CONV) && I_SAMPLE_VALID && !set_done && (avg_cnt == ratio_n - 7'h01);

  // Shift an accumulated sample sum by the ratio: mean of 2^ratio samples
  function [15:0] arc_avg;
    input [22:0] sum;
    input [2:0] ratio;
    begin
      arc_avg = sum[ratio +: 16];
    end
  endfunction

  // Result bit that stands in the MSB slot after the given shift
  function arc_ser_bit;
    input [2:0] ch;
    input [4:0] bits;
    reg [15:0] word;
    begin
      word = store[ch] << bits;
      arc_ser_bit = word[15];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Filter output buffer
  // --------------------------------------------------------------------------
  arc_buf2 #(.WIDTH(19)) u_buf (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_valid(buf_in_valid),
    .o_ready(buf_in_ready),
    .i_data({ch_idx, arc_avg(sum_next, O_OVERSAMPLING_RATIO)}),
    .o_valid(buf_out_valid),
    .i_ready(state != ST_IDLE),
    .o_data(buf_out)
  );

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= ST_IDLE;
      conv_cnt <= 16'h0000;
      conv_len <= 16'h0000;
      ch_idx <= 3'h0;
      avg_cnt <= 7'h00;
      acc <= 23'h00_0000;
      conv_a_q <= 1'b0;
      O_BUSY <= 1'b0;
      O_SAMPLE_REQ <= 1'b0;
      O_OVERSAMPLING_RATIO <= 3'h0;
      set_done <= 1'b0;
      for (k = 0; k < NUM_CH; k = k + 1) begin
        store[k] <= 16'h0000;
        pend[k] <= 16'h0000;
      end
    end else begin
      conv_a_q <= I_CONVERSION_START_GROUP_A && I_CONVERSION_START_GROUP_B;
      O_SAMPLE_REQ <= 1'b0;
      if (buf_out_valid) begin
        pend[buf_out[18:16]] <= buf_out[15:0];
      end
      case (state)
        ST_IDLE: begin
          if (start_rise) begin
            state <= ST_CONV;
            O_BUSY <= 1'b1;
            conv_cnt <= 16'h0000;
            conv_len <= BASE_CONV_CYC[15:0] << O_OVERSAMPLING_RATIO;
            ch_idx <= 3'h0;
            avg_cnt <= 7'h00;
            acc <= 23'h00_0000;
            set_done <= 1'b0;
            O_SAMPLE_REQ <= 1'b1;
          end
        end
        ST_CONV: begin
          conv_cnt <= conv_cnt + 16'h0001;
          if (sample_take) begin
            if (avg_cnt == ratio_n - 7'h01) begin
              acc <= 23'h00_0000;
              avg_cnt <= 7'h00;
              ch_idx <= ch_idx + 3'h1;
              set_done <= last_ch;
            end else begin
              acc <= sum_next;
              avg_cnt <= avg_cnt + 7'h01;
            end
          end
          if (conv_cnt + `ARC_UPDATE_LEAD_CYC >= conv_len) begin
            state <= ST_FLUSH;
          end else if (!set_done && (I_SAMPLE_VALID || conv_cnt[3:0] == 4'h0)) begin
            O_SAMPLE_REQ <= 1'b1;
          end
        end
        ST_FLUSH: begin
          conv_cnt <= conv_cnt + 16'h0001;
          if (!buf_out_valid) begin
            for (k = 0; k < NUM_CH; k = k + 1) begin
              store[k] <= pend[k];
            end
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          conv_cnt <= conv_cnt + 16'h0001;
          if (conv_cnt + 16'h0001 >= conv_len) begin
            O_BUSY <= 1'b0;
            O_OVERSAMPLING_RATIO <= I_OVERSAMPLE_RATIO_SELECT_PINS;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Readout ports, independent of busy
  // --------------------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      sclk_q <= 1'b0;
      rd_idx <= 4'h0;
      bit_cnt <= 5'h00;
      ser_ch <= 3'h0;
      O_DB <= 16'h0000;
      O_DB_OE <= 1'b0;
      O_DOUT_A <= 1'b0;
      O_DOUT_B <= 1'b0;
      O_DOUT_OE <= 1'b0;
      O_FIRST_DATA <= 1'b0;
      O_FIRST_DATA_OE <= 1'b0;
    end else begin
      cs_q <= I_CS_N;
      rd_q <= I_RD_N;
      sclk_q <= I_SCLK;
      O_DB_OE <= !I_CS_N && (if_kind != `ARC_IF_SER);
      O_DOUT_OE <= !I_CS_N && (if_kind == `ARC_IF_SER);
      O_FIRST_DATA_OE <= !I_CS_N;
      if (I_CS_N) begin
        O_FIRST_DATA <= 1'b0;
      end
      if (cs_fall && if_kind == `ARC_IF_SER) begin
        O_DOUT_A <= store[ser_ch][15];
        O_DOUT_B <= store[ser_ch + 3'h4][15];
        O_FIRST_DATA <= (ser_ch == 3'h0);
      end
      if (rd_fall && if_kind == `ARC_IF_WORD) begin
        O_DB <= store[rd_idx[2:0]];
        O_FIRST_DATA <= (rd_idx[2:0] == 3'h0);
        rd_idx <= {1'b0, rd_idx[2:0] + 3'h1};
      end
      if (rd_fall && if_kind == `ARC_IF_BYTE) begin
        O_DB <= {8'h00, (rd_idx[0] ^ I_HIGH_BYTE_FIRST) ? store[rd_idx[3:1]][15:8] : store[rd_idx[3:1]][7:0]};
        O_FIRST_DATA <= (rd_idx[3:1] == 3'h0);
        rd_idx <= rd_idx + 4'h1;
      end
      if (if_kind == `ARC_IF_SER) begin
        if (sclk_fall) begin
          if (bit_cnt == `ARC_SER_BITS - 5'h01) begin
            bit_cnt <= 5'h00;
            ser_ch <= ser_ch + 3'h1;
            O_FIRST_DATA <= 1'b0;
          end else begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        if (sclk_rise && bit_cnt != 5'h00) begin
          O_DOUT_A <= arc_ser_bit(ser_ch, bit_cnt);
          O_DOUT_B <= arc_ser_bit(ser_ch + 3'h4, bit_cnt);
        end
      end
      if (O_BUSY && state == ST_FLUSH && !buf_out_valid) begin
        rd_idx <= 4'h0;
        bit_cnt <= 5'h00;
        ser_ch <= 3'h0;
      end
    end
  end
endmodule

// File: test/arc_readout_ctrl_sva.sv
// Port checker for the readout control block
`timescale 1ns/10ps
module arc_readout_ctrl_sva #(
  parameter BASE_CONV_CYC = 200
) (
  input wire I_CLK,
  input wire I_RESET_N,
  input wire [2:0] I_OVERSAMPLE_RATIO_SELECT_PINS,
  input wire I_CS_N,
  input wire I_RD_N,
  input wire I_SCLK,
  input wire O_SAMPLE_REQ,
  input wire O_BUSY,
  input wire [2:0] O_OVERSAMPLING_RATIO,
  input wire [15:0] O_DB,
  input wire O_DB_OE,
  input wire O_DOUT_A,
  input wire O_DOUT_OE,
  input wire O_FIRST_DATA_OE
);
  reg [15:0] bcnt;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // ----------------------------------------------------------------
  // Busy length counter
  // ----------------------------------------------------------------
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) bcnt <= 16'h0000;
    else if (O_BUSY) bcnt <= bcnt + 16'h0001;
    else bcnt <= 16'h0000;
  end
  AST_RATIO_LATCH: assert property ($fell(O_BUSY) |-> O_OVERSAMPLING_RATIO == $past(I_OVERSAMPLE_RATIO_SELECT_PINS))
    else $error("ratio not caught at busy fall");
  AST_RATIO_HOLD: assert property (!$fell(O_BUSY) |-> $stable(O_OVERSAMPLING_RATIO))
    else $error("ratio changed away from busy fall");
  AST_BUSY_LEN: assert property ($fell(O_BUSY) |-> bcnt >= (BASE_CONV_CYC << $past(O_OVERSAMPLING_RATIO)))
    else $error("busy too short for ratio");
  AST_REQ_BUSY: assert property (O_SAMPLE_REQ |-> O_BUSY)
    else $error("sample request outside conversion");
  AST_DB_HOLD: assert property ((!I_CS_N && $stable(I_RD_N))[*5] |=> $stable(O_DB))
    else $error("parallel data moved without strobe");
  AST_DOUT_HOLD: assert property ((!I_CS_N && $stable(I_SCLK))[*5] |=> $stable(O_DOUT_A))
    else $error("serial data moved without clock");
  AST_DB_OE: assert property (O_DB_OE |-> !$past(I_CS_N))
    else $error("parallel bus driven while deselected");
  AST_DOUT_OE: assert property (O_DOUT_OE |-> !$past(I_CS_N))
    else $error("serial line driven while deselected");
  AST_FD_OE: assert property (O_FIRST_DATA_OE |-> !$past(I_CS_N))
    else $error("first data driven while deselected");
endmodule
bind arc_readout_ctrl arc_readout_ctrl_sva #(.BASE_CONV_CYC(BASE_CONV_CYC)) i_sva (.I_CLK, .I_RESET_N,
  .I_OVERSAMPLE_RATIO_SELECT_PINS, .I_CS_N, .I_RD_N, .I_SCLK, .O_SAMPLE_REQ, .O_BUSY, .O_OVERSAMPLING_RATIO,
  .O_DB, .O_DB_OE, .O_DOUT_A, .O_DOUT_OE, .O_FIRST_DATA_OE);

// File: test/arc_src_model.sv
// Raw sample source model facing the readout block
`timescale 1ns/10ps
module arc_src_model (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_req,
  input wire i_busy,
  input wire [2:0] i_ratio,
  output reg o_valid,
  output reg [15:0] o_data
);
  reg [15:0] cnt;
  reg [6:0] conv;
  reg busy_d;
  wire [15:0] ch_full = cnt >> i_ratio;
  wire [15:0] base = {1'b0, conv, 5'h00, ch_full[2:0]};
  wire [15:0] wobble = (i_ratio == 3'h0) ? 16'h0000 : (cnt[0] ? 16'h0001 : 16'hffff);
  // ----------------------------------------------------------------
  // Samples alternate one above and below a fixed value per channel at a nonzero ratio; at ratio 0 they equal that value
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= 16'h0000;
      conv <= 7'h01;
      busy_d <= 1'b0;
      o_valid <= 1'b0;
      o_data <= 16'h0000;
    end else begin
      busy_d <= i_busy;
      o_valid <= i_req;
      if (!i_busy) begin
        cnt <= 16'h0000;
      end else if (i_req) begin
        cnt <= cnt + 16'h0001;
      end
      if (busy_d && !i_busy) begin
        conv <= conv + 7'h01;
      end
      if (i_req) o_data <= base + wobble;
      else o_data <= ~o_data;
    end
  end
endmodule

// File: test/tb.sv
// Self-checking bench for the readout control block
`timescale 1ns/10ps
module tb;
  localparam BASE = 40;
  reg clk = 0;
  reg rst_n = 0;
  reg st = 0;
  reg [2:0] os = 3'h5;
  reg [2:0] er = 3'h0;
  reg ksel = 0;
  reg bsel = 0;
  reg hbf = 1;
  reg cs_n = 1;
  reg rd_n = 1;
  reg sclk = 0;
  wire sv, req, busy, da, dbb, doe, fd, fdoe, dboe;
  wire [15:0] sd, dbus;
  wire [2:0] ratio;
  integer err_count = 0;
  integer check_count = 0;
  integer conv, i, b, n, k;
  reg [15:0] w, v;
  time t0;
  always #10 clk = ~clk;
  arc_readout_ctrl #(.BASE_CONV_CYC(BASE)) i_dut (.I_CLK(clk), .I_RESET_N(rst_n),
    .I_CONVERSION_START_GROUP_A(st), .I_CONVERSION_START_GROUP_B(st), .I_OVERSAMPLE_RATIO_SELECT_PINS(os),
    .I_INTERFACE_KIND_SELECT(ksel), .I_BYTE_MODE_SELECT(bsel), .I_HIGH_BYTE_FIRST(hbf), .I_CS_N(cs_n),
    .I_RD_N(rd_n), .I_SCLK(sclk), .I_SAMPLE_VALID(sv), .I_SAMPLE_DATA(sd), .O_SAMPLE_REQ(req), .O_BUSY(busy),
    .O_OVERSAMPLING_RATIO(ratio), .O_DB(dbus), .O_DB_OE(dboe), .O_DOUT_A(da), .O_DOUT_B(dbb), .O_DOUT_OE(doe),
    .O_FIRST_DATA(fd), .O_FIRST_DATA_OE(fdoe));
  arc_src_model i_src (.i_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_busy(busy), .i_ratio(ratio),
    .o_valid(sv), .o_data(sd));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [15:0] exp_val(input integer c, input integer ch);
    exp_val = {1'b0, c[6:0], 5'h00, ch[2:0]};
  endfunction
  task step;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Read all channels, one select frame per channel
  // ----------------------------------------------------------------
  task rd_all(input integer kind, input integer c);
    begin
      for (i = 0; i < 8; i = i + 1) begin
        cs_n = 1'b0;
        repeat (4) step;
        if (kind == 2) begin
          for (b = 15; b >= 0; b = b - 1) begin
            if (b == 15) chk({15'h0000, fd}, {15'h0000, i == 0});
            sclk = 1'b1;
            repeat (4) step;
            w[b] = da;
            v[b] = dbb;
            sclk = 1'b0;
            repeat (3) step;
          end
          if (i < 4) chk(v, exp_val(c, i + 4));
        end else begin
          for (b = 0; b <= kind; b = b + 1) begin
            rd_n = 1'b0;
            repeat (4) step;
            if (kind == 0) w = dbus;
            else if (hbf ^ (b == 1)) w[15:8] = dbus[7:0];
            else w[7:0] = dbus[7:0];
            rd_n = 1'b1;
            repeat (4) step;
          end
        end
        chk(w, exp_val(c, i));
        cs_n = 1'b1;
        repeat (3) step;
      end
      chk({15'h0000, busy}, 16'h0001);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n = $urandom(92426);
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    for (conv = 1; conv <= 7; conv = conv + 1) begin
      k = conv % 3;
      ksel = k != 0;
      bsel = k == 1;
      hbf = $urandom % 2;
      step;
      st = 1'b1;
      step;
      st = 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 10) begin
        step;
        n = n + 1;
      end
      t0 = $time;
      if (conv > 1) rd_all(k, conv - 1);
      n = 0;
      while (busy !== 1'b0 && n < 5000) begin
        step;
        n = n + 1;
      end
      chk({13'h0000, ratio}, {13'h0000, os});
      chk({15'h0000, ($time - t0) / 20 >= (BASE << er)}, 16'h0001);
      er = os;
      os = 3'h5 + ($urandom % 3);
      $display("test conversion %0d mode %0d done", conv, k);
    end
    stop_test;
  end
  initial begin
    #(20 * 60000);
    err_count = err_count + 1;
    stop_test;
  end
endmodule
